// ---- ddr_burst_sram_port.v ----
// Burst static RAM port: pin sampling, burst sequencing, byte lanes and memory array
`timescale 1ns/1ps
`default_nettype none
`include "burst_sram_map.vh"
// Functional notes
// - The input clock stays stable while the PLL is enabled; the port acts only on clean edges.
// - Burst addresses step the two low address bits modulo four from the start value.
// - A write load at K rise t captures words at K(t+1), K#(t+1), K(t+2), K#(t+2).
// - A read load at K rise t drives words at C#(t+1), C(t+2), C#(t+2), C(t+3).
// - Read data launches on output clock rises, or on input clock rises if both are high.
// - Load strobe and direction are sampled only on the rising edge of the true input clock.
// - The data bus is released from power-up until a read is commanded.
// - Load strobe and direction are ignored at the K rise after a load.
// - Address is ignored in idle cycles and during a burst; its low two bits start the burst.
// - Each active-low byte-lane enable gates its lane at every write data edge.
module ddr_burst_sram_port #(
  parameter DATA_W     = `DATA_W,
  parameter LANE_W     = `LANE_W,
  parameter ADDR_W     = `ADDR_W,
  parameter MEM_ADDR_W = `MEM_ADDR_W
) (
  // System
  input  wire              clk_i,
  input  wire              reset_i,
  // Input and output clock pairs from the controller
  input  wire              k_clk_i,
  input  wire              k_clk_n_i,
  input  wire              c_clk_i,
  input  wire              c_clk_n_i,
  // Command pins
  input  wire              load_strobe_n_i,
  input  wire              read_not_write_i,
  input  wire [ADDR_W-1:0] address_i,
  input  wire              byte_lane_low_we_n_i,
  input  wire              byte_lane_high_we_n_i,
  // Shared data bus, three signals
  input  wire [DATA_W-1:0] shared_data_bus_i,
  output reg  [DATA_W-1:0] shared_data_bus_o,
  output reg               shared_data_bus_oe_n_o,
  // Status
  output reg               init_done_o
);
  // Pin sampling: two flops each, first stage read only by the second
  localparam NS = 6 + 1 + 1 + ADDR_W + 2 + DATA_W;
  wire [NS-1:0] pins = {k_clk_i, k_clk_n_i, c_clk_i, c_clk_n_i, load_strobe_n_i,
                        read_not_write_i, byte_lane_low_we_n_i, byte_lane_high_we_n_i,
                        address_i, 2'b00, shared_data_bus_i};
  reg  [NS-1:0] s1_reg;
  reg  [NS-1:0] s2_reg;
  reg  [3:0]    clk_d_reg;
  reg  [1:0]    warm_reg;
  always @(posedge clk_i) begin
    if (reset_i) begin
      s1_reg <= {NS{1'b0}};
      s2_reg <= {NS{1'b0}};
      clk_d_reg <= 4'h0;
      warm_reg <= 2'd0;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      clk_d_reg <= s2_reg[NS-1:NS-4];
      if (warm_reg != 2'd3)
        warm_reg <= warm_reg + 2'd1;
    end
  end
  wire              k_s   = s2_reg[NS-1];
  wire              kn_s  = s2_reg[NS-2];
  wire              c_s   = s2_reg[NS-3];
  wire              cn_s  = s2_reg[NS-4];
  wire              ld_n  = s2_reg[NS-5];
  wire              rd    = s2_reg[NS-6];
  wire [1:0]        bw_n  = {s2_reg[NS-8], s2_reg[NS-7]};
  wire [ADDR_W-1:0] addr  = s2_reg[DATA_W+2+ADDR_W-1:DATA_W+2];
  wire [DATA_W-1:0] din   = s2_reg[DATA_W-1:0];
  // Edges found only on clean sampled transitions; a stopped clock gives none
  // No edges until the pipeline holds real samples; reset zeros would fake an idle cycle
  wire primed  = (warm_reg == 2'd3);
  wire k_rise  = k_s & ~clk_d_reg[3] & primed;
  wire kn_rise = kn_s & ~clk_d_reg[2] & primed;
  wire c_rise  = c_s & ~clk_d_reg[1] & primed;
  wire cn_rise = cn_s & ~clk_d_reg[0] & primed;
  wire c_parked = c_s & cn_s;
  wire first_rise  = c_parked ? kn_rise : cn_rise;
  wire second_rise = c_parked ? k_rise : c_rise;

  function [1:0] burst_step;
    input [1:0] start;
    input [1:0] idx;
    burst_step = start + idx;
  endfunction

  reg [DATA_W-1:0] mem [0:(1<<MEM_ADDR_W)-1];

  // Burst state
  localparam ST_IDLE  = 2'b00;
  localparam ST_WRITE = 2'b01;
  localparam ST_READ  = 2'b10;
  reg [1:0]            state_reg;
  reg [2:0]            beat_reg;
  reg [MEM_ADDR_W-1:0] base_reg;
  reg [2:0]            idle_cnt_reg;
  // Two-entry read buffer between array and bus launch
  reg [DATA_W-1:0] buf_data_reg [0:1];
  reg              wr_ptr_reg;
  reg              rd_ptr_reg;
  reg [1:0]        count_reg;
  reg [2:0]        fetch_reg;
  reg [2:0]        sent_reg;
  reg [1:0]        rd_start_reg;
  reg [MEM_ADDR_W-1:0] rd_base_reg;
  reg              rd_wait_reg;
  wire buf_in_ready  = (count_reg != 2'd2);
  wire buf_out_valid = (count_reg != 2'd0);
  wire fetch_valid   = (fetch_reg != 3'd0);
  wire push = fetch_valid & buf_in_ready;
  // Launch edge alternates: first-clock edge for even words, second for odd
  wire launch_edge = sent_reg[0] ? second_rise : first_rise;
  wire pop = buf_out_valid & launch_edge & ~rd_wait_reg & (sent_reg != 3'd0);
  wire [2:0] fidx = `BURST_LEN - fetch_reg;
  wire [MEM_ADDR_W-1:0] faddr = {rd_base_reg[MEM_ADDR_W-1:2], burst_step(rd_start_reg, fidx[1:0])};

  wire [1:0] widx = beat_reg[1:0];
  wire [MEM_ADDR_W-1:0] waddr = {base_reg[MEM_ADDR_W-1:2], burst_step(base_reg[1:0], widx)};
  wire wr_edge = beat_reg[0] ? kn_rise : k_rise;
  wire load_ok = (state_reg == ST_IDLE) & init_done_o & (sent_reg == 3'd0);

  always @(posedge clk_i) begin
    if (wr_edge && state_reg == ST_WRITE) begin
      if (!bw_n[0])
        mem[waddr][LANE_W-1:0] <= din[LANE_W-1:0];
      if (!bw_n[1])
        mem[waddr][DATA_W-1:LANE_W] <= din[DATA_W-1:LANE_W];
    end
    if (push)
      buf_data_reg[wr_ptr_reg] <= mem[faddr];
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      beat_reg <= 3'd0;
      base_reg <= {MEM_ADDR_W{1'b0}};
      idle_cnt_reg <= 3'd0;
      init_done_o <= 1'b0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
      fetch_reg <= 3'd0;
      sent_reg <= 3'd0;
      rd_start_reg <= 2'b00;
      rd_base_reg <= {MEM_ADDR_W{1'b0}};
      rd_wait_reg <= 1'b0;
      shared_data_bus_o <= {DATA_W{1'b0}};
      shared_data_bus_oe_n_o <= 1'b1;
    end else begin
      // Idle cycles counted after reset before any load is accepted
      if (k_rise && !init_done_o) begin
        if (ld_n) begin
          if (idle_cnt_reg == `INIT_IDLE_CYCLES - 3'd1)
            init_done_o <= 1'b1;
          idle_cnt_reg <= idle_cnt_reg + 3'd1;
        end else
          idle_cnt_reg <= 3'd0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (k_rise && load_ok && !ld_n) begin
            beat_reg <= 3'd0;
            base_reg <= addr[MEM_ADDR_W-1:0];
            if (rd) begin
              state_reg <= ST_READ;
              rd_start_reg <= addr[1:0];
              rd_base_reg <= addr[MEM_ADDR_W-1:0];
              fetch_reg <= `BURST_LEN;
              sent_reg <= `BURST_LEN;
              rd_wait_reg <= 1'b1;
            end else
              state_reg <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          // Control pins at K(t+1) are ignored; burst owns the slot
          if (wr_edge) begin
            beat_reg <= beat_reg + 3'd1;
            if (beat_reg == `BURST_LEN - 3'd1)
              state_reg <= ST_IDLE;
          end
        end
        ST_READ: begin
          if (k_rise) begin
            beat_reg <= beat_reg + 3'd1;
            if (beat_reg == 3'd1)
              state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // Skip the first-clock rise that precedes t+1
      if (rd_wait_reg && k_rise && state_reg == ST_READ)
        rd_wait_reg <= 1'b0;
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
        fetch_reg <= fetch_reg - 3'd1;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
        sent_reg <= sent_reg - 3'd1;
        shared_data_bus_o <= buf_data_reg[rd_ptr_reg];
        shared_data_bus_oe_n_o <= 1'b0;
      end else if (sent_reg == 3'd0 && launch_edge)
        shared_data_bus_oe_n_o <= 1'b1;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  // Stopped clocks give no edges, so burst state and outputs hold; the pin sample flops still follow the pins
endmodule // ddr_burst_sram_port
`default_nettype wire

// ---- burst_sram_map.vh ----
// Constants for the double-data-rate burst static RAM port
`ifndef BURST_SRAM_MAP_VH
`define BURST_SRAM_MAP_VH
`define BURST_LEN        3'd4
`define DATA_W           18
`define LANE_W           9
`define ADDR_W           20
`define MEM_ADDR_W       8
`define INIT_IDLE_CYCLES 3'd4
`endif

// ---- sram_port_chk.sv ----
// Checker on the burst static RAM port outputs
`timescale 1ns/1ps
`default_nettype none
module sram_port_chk (
  // Clocks and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        k_clk_i,
  input wire logic        k_clk_n_i,
  input wire logic        c_clk_i,
  input wire logic        c_clk_n_i,
  // Outputs
  input wire logic [17:0] shared_data_bus_o,
  input wire logic        shared_data_bus_oe_n_o,
  input wire logic        init_done_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_still; $stable({k_clk_i, k_clk_n_i, c_clk_i, c_clk_n_i}) [*5]; endsequence
  sequence s_words; !shared_data_bus_oe_n_o [*8]; endsequence
  property p_reset;
    disable iff (1'b0) reset_i |=> shared_data_bus_oe_n_o && !init_done_o && !shared_data_bus_o;
  endproperty
  property p_frozen; s_still |=> $stable({shared_data_bus_o, shared_data_bus_oe_n_o}); endproperty
  property p_first; $fell(shared_data_bus_oe_n_o) |-> c_clk_n_i; endproperty
  property p_hold; $fell(shared_data_bus_oe_n_o) |-> s_words; endproperty
  property p_end; $fell(shared_data_bus_oe_n_o) |-> ##[28:36] shared_data_bus_oe_n_o; endproperty
  property p_off_edge; $rose(shared_data_bus_oe_n_o) |-> c_clk_n_i; endproperty
  property p_early; !shared_data_bus_oe_n_o |-> init_done_o; endproperty
  property p_keep; init_done_o |=> init_done_o; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  a_frozen: assert property (p_frozen) else $error("outputs moved with clocks still");
  a_first: assert property (p_first) else $error("first word off a launch edge");
  a_hold: assert property (p_hold) else $error("read burst cut short");
  a_end: assert property (p_end) else $error("bus not released after burst");
  a_off_edge: assert property (p_off_edge) else $error("bus released off edge");
  a_early: assert property (p_early) else $error("bus driven before init");
  a_keep: assert property (p_keep) else $error("init status dropped");
endmodule // sram_port_chk
bind ddr_burst_sram_port sram_port_chk i_chk (
  .clk_i                  (clk_i),
  .reset_i                (reset_i),
  .k_clk_i                (k_clk_i),
  .k_clk_n_i              (k_clk_n_i),
  .c_clk_i                (c_clk_i),
  .c_clk_n_i              (c_clk_n_i),
  .shared_data_bus_o      (shared_data_bus_o),
  .shared_data_bus_oe_n_o (shared_data_bus_oe_n_o),
  .init_done_o            (init_done_o)
);
`default_nettype wire

// ---- host_clocks.sv ----
// Host controller model: input and output clock pairs
`timescale 1ns/1ps
`default_nettype none
module host_clocks (
  // Controls
  input  wire logic run_i,
  input  wire logic park_c_i,
  // Clock pairs
  output var  logic k_o,
  output wire logic kn_o,
  output wire logic c_o,
  output wire logic cn_o
);
  // Loop mode stays selected: no loop-disable pin reaches the port
  initial k_o = 1'b1;
  // Steady 160 ns period; the port has no tracking loop, so speed only scales time
  always #80 k_o = run_i ? ~k_o : 1'b1;
  // Stopped clocks all park high for a clean restart
  assign kn_o = run_i ? ~k_o : 1'b1;
  assign c_o  = park_c_i | k_o;
  assign cn_o = park_c_i | kn_o;
endmodule // host_clocks
`default_nettype wire

// ---- tb.sv ----
// Testbench for the burst static RAM port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0, reset_i = 1'b1, run = 1'b1, park = 1'b0;
  logic        k, kn, c, cn, oe_n, init_done;
  logic        ld_n = 1'b1, rnw = 1'b0, bl_n = 1'b0, bh_n = 1'b0;
  logic [19:0] addr = 20'h0_0000;
  logic [17:0] host_d = 18'h0_0000, dout, bus;
  logic [17:0] mem [0:255];
  int          miscompares = 0, samples_checked = 0;
  always #5 clk_i = ~clk_i;
  assign bus = oe_n ? host_d : dout;
  host_clocks i_host (.run_i(run), .park_c_i(park), .k_o(k), .kn_o(kn), .c_o(c), .cn_o(cn));
  ddr_burst_sram_port i_dut (.clk_i(clk_i), .reset_i(reset_i), .k_clk_i(k), .k_clk_n_i(kn),
    .c_clk_i(c), .c_clk_n_i(cn), .load_strobe_n_i(ld_n), .read_not_write_i(rnw),
    .address_i(addr), .byte_lane_low_we_n_i(bl_n), .byte_lane_high_we_n_i(bh_n),
    .shared_data_bus_i(bus), .shared_data_bus_o(dout), .shared_data_bus_oe_n_o(oe_n),
    .init_done_o(init_done));
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Lands mid half-period, after the port's synchronisers have settled
  task automatic k_step(input int n);
    repeat (n) @(k);
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  task automatic burst(input logic rd, input logic [7:0] a, input logic [1:0] ln);
    logic [7:0] idx;
    @(negedge k);
    k_step(0);
    {ld_n, rnw, addr, bh_n, bl_n} = {1'b0, rd, 12'h5a5, a, ln};
    k_step(1);
    {rnw, addr} = {~rd, 20'h0_0000};
    for (int i = 0; i < 7; i++) begin
      k_step(1);
      ld_n = (i != 0);
      idx = {a[7:2], a[1:0] + 2'(rd ? i - 2 : i)};
      if (!rd && i < 4) begin
        host_d = {a, 2'(i), a};
        mem[idx] = {ln[1] ? mem[idx][17:9] : host_d[17:9], ln[0] ? mem[idx][8:0] : host_d[8:0]};
      end
      if (!rd && i == 4) host_d = ~host_d;
      if (rd && i > 1 && i < 6) chk("read word", mem[idx], bus);
      if (i == 6 || !rd) chk("bus released", 18'h0_0001, {17'h0_0000, oe_n});
    end
    $display("burst %b at %h done", rd, a);
  endtask
  task automatic power_up();
    repeat (8) @(posedge clk_i);
    #1 reset_i = 1'b0;
    chk("bus at power-up", 18'h0_0001, {17'h0_0000, oe_n});
    k_step(4);
    chk("init after two idle", 18'h0_0000, {17'h0_0000, init_done});
    k_step(6);
    chk("init done", 18'h0_0001, {17'h0_0000, init_done});
    $display("power-up done");
  endtask
  // Stops with K high; the parked read's last word sits at 8'h11
  task automatic clock_stop();
    @(posedge k);
    @(posedge clk_i);
    #1 {run, ld_n} = 2'b00;
    repeat (30) @(posedge clk_i);
    #1;
    chk("bus while stopped", 18'h0_0001, {17'h0_0000, oe_n});
    chk("data while stopped", mem[8'h11], dout);
    {run, ld_n} = 2'b11;
    $display("clock stop done");
  endtask
  task automatic reset_again();
    @(posedge clk_i);
    #1 reset_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 reset_i = 1'b0;
    chk("bus after reset", 18'h0_0001, {17'h0_0000, oe_n});
    chk("data after reset", 18'h0_0000, dout);
    chk("init after reset", 18'h0_0000, {17'h0_0000, init_done});
    k_step(10);
    chk("init done again", 18'h0_0001, {17'h0_0000, init_done});
    $display("reset in mid-run done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #60000;
    miscompares++;
    summarize();
  end
  initial begin
    power_up();
    burst(0, 8'h12, 2'b00);
    burst(1, 8'h10, 2'b00);
    burst(0, 8'h11, 2'b10);
    burst(0, 8'h10, 2'b01);
    burst(1, 8'h13, 2'b00);
    park = 1'b1;
    burst(1, 8'h12, 2'b00);
    park = 1'b0;
    clock_stop();
    burst(1, 8'h11, 2'b00);
    reset_again();
    burst(1, 8'h12, 2'b00);
    summarize();
  end
endmodule // tb
`default_nettype wire
